/* common/ivm_defines.vh */
// constants for the interrupt vector mapper
`ifndef IVM_DEFINES_VH
`define IVM_DEFINES_VH
`define IVM_NUM_VECTORS 26
`define IVM_VEC_W 5
`define IVM_VEC_RESET 5'h00
`define IVM_VEC_NMI 5'h01
`define IVM_VEC_VLM 5'h02
`define IVM_VEC_PORTA 5'h03
`define IVM_VEC_PORTB 5'h04
`define IVM_VEC_PORTC 5'h05
`define IVM_VEC_RTC_COUNT 5'h06
`define IVM_VEC_RTC_TICK 5'h07
`define IVM_VEC_TMA_LOW_UNF 5'h08
`define IVM_VEC_TMA_HIGH_UNF 5'h09
`define IVM_VEC_TMA_CMP0 5'h0a
`define IVM_VEC_TMA_CMP1 5'h0b
`define IVM_VEC_TMA_CMP2 5'h0c
`define IVM_VEC_TMB 5'h0d
`define IVM_VEC_TMD_OVF 5'h0e
`define IVM_VEC_TMD_TRIG 5'h0f
`define IVM_VEC_ACMP 5'h10
`define IVM_VEC_ADC_RDY 5'h11
`define IVM_VEC_ADC_WIN 5'h12
`define IVM_VEC_TW_TGT 5'h13
`define IVM_VEC_TW_CTL 5'h14
`define IVM_VEC_SPI 5'h15
`define IVM_VEC_SER_RX 5'h16
`define IVM_VEC_SER_EMPTY 5'h17
`define IVM_VEC_SER_TX 5'h18
`define IVM_VEC_EE 5'h19
`define IVM_FLAGS_RESET 26'h0000000
`define IVM_EN_RESET 26'h0000000
`endif

/* logic/ivm_source_flags.v */
// per-source flag and enable storage
`timescale 1ns/1ps
module ivm_source_flags #(
   parameter N = 26
) (
   input wire sys_clk,
   input wire rst,
   input wire clk_en,
   input wire [N-1:0] set_evt,
   input wire [N-1:0] clr_flag,
   input wire [N-1:0] en_wr,
   input wire [N-1:0] en_wdata,
   output reg [N-1:0] source_flag_bit,
   output reg [N-1:0] source_enable_bit
);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         source_flag_bit <= {N{1'b0}};
         source_enable_bit <= {N{1'b0}};
      end else if (clk_en) begin
         // set wins over clear
         source_flag_bit <= set_evt | (source_flag_bit & ~clr_flag);
         source_enable_bit <= (en_wdata & en_wr) | (source_enable_bit & ~en_wr);
      end
   end
endmodule

/* logic/ivm_prio_enc.v */
// lowest-index pending vector encoder
`timescale 1ns/1ps
module ivm_prio_enc #(
   parameter N = 26,
   parameter W = 5
) (
   input wire [N-1:0] req,
   output reg any,
   output reg [W-1:0] idx
);
   integer i;
   always @* begin
      any = 1'b0;
      idx = {W{1'b0}};
      for (i = N-1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            any = 1'b1;
            idx = i[W-1:0];
         end
      end
   end
endmodule

/* logic/ivm_mapper.v */
// interrupt vector mapper top
`timescale 1ns/1ps
`include "ivm_defines.vh"
module ivm_mapper (
   input wire sys_clk,
   input wire rst,
   input wire clk_en,
   input wire global_irq_enable,
   input wire checksum_scan_nmi,
   input wire voltage_level_monitor_irq,
   input wire [2:0] port_pin_change,
   input wire rtc_counter_irq,
   input wire periodic_tick_irq,
   input wire low_half_underflow,
   input wire timer_a_overflow,
   input wire high_half_underflow,
   input wire [2:0] timer_a_compare,
   input wire [2:0] timer_a_low_compare,
   input wire timer_b_irq,
   input wire timer_d_overflow,
   input wire timer_d_trigger,
   input wire comparator_irq,
   input wire conversion_result_ready,
   input wire window_compare_hit,
   input wire two_wire_target_irq,
   input wire two_wire_controller_irq,
   input wire spi_irq,
   input wire receive_complete,
   input wire tx_buffer_empty,
   input wire transmit_complete,
   input wire eeprom_ready_irq,
   input wire [25:0] flag_clear,
   input wire [25:0] enable_write,
   input wire [25:0] enable_wdata,
   output reg [25:0] peripheral_flag_register,
   output reg [25:0] peripheral_irq_control_register,
   output reg [25:0] vector_request,
   output reg irq_valid,
   output reg irq_nmi,
   output reg [4:0] irq_vector
);
   localparam N = `IVM_NUM_VECTORS;
   localparam W = `IVM_VEC_W;

   // one-hot mask of a vector number
   function [N-1:0] vec_onehot;
      input [W-1:0] v;
      begin
         vec_onehot = {{(N-1){1'b0}}, 1'b1} << v;
      end
   endfunction

   reg [N-1:0] set_evt;
   wire [N-1:0] flags;
   wire [N-1:0] enables;
   wire [N-1:0] raw_req;
   wire [N-1:0] nmi_req;
   wire [N-1:0] maskable_req;
   wire [N-1:0] nmi_mask;
   wire [N-1:0] reset_mask;
   reg [N-1:0] req_nxt;
   wire any;
   wire [W-1:0] idx;

   reg [N-1:0] flag_reg_nxt;
   reg [N-1:0] ctrl_reg_nxt;
   reg [N-1:0] vec_req_nxt;
   reg irq_valid_nxt;
   reg irq_nmi_nxt;
   reg [W-1:0] irq_vector_nxt;

   // system sources
   wire evt_checksum_nmi;
   wire evt_level_monitor;
   // port pin changes
   wire evt_port_a;
   wire evt_port_b;
   wire evt_port_c;
   // real-time counter
   wire evt_rtc_count;
   wire evt_rtc_tick;
   // timer A
   wire evt_tma_low_unf;
   wire evt_tma_high_unf;
   wire evt_tma_cmp0;
   wire evt_tma_cmp1;
   wire evt_tma_cmp2;
   // timers B and D
   wire evt_tmb;
   wire evt_tmd_ovf;
   wire evt_tmd_trig;
   // analog comparator and converter
   wire evt_comparator;
   wire evt_conv_ready;
   wire evt_conv_window;
   // two-wire and serial peripheral
   wire evt_tw_target;
   wire evt_tw_controller;
   wire evt_spi;
   // serial port
   wire evt_ser_rx;
   wire evt_ser_empty;
   wire evt_ser_tx;
   // memory controller
   wire evt_eeprom;

   // one instance per group feeds its own vectors only
   assign evt_checksum_nmi = checksum_scan_nmi;
   assign evt_level_monitor = voltage_level_monitor_irq;

   // one port instance each
   assign evt_port_a = port_pin_change[0];
   assign evt_port_b = port_pin_change[1];
   assign evt_port_c = port_pin_change[2];

   // counter and tick share the rtc instance
   assign evt_rtc_count = rtc_counter_irq;
   assign evt_rtc_tick = periodic_tick_irq;

   // split and normal mode sources share the low underflow and compare vectors
   assign evt_tma_low_unf = low_half_underflow | timer_a_overflow;
   assign evt_tma_high_unf = high_half_underflow;
   assign evt_tma_cmp0 = timer_a_compare[0] | timer_a_low_compare[0];
   assign evt_tma_cmp1 = timer_a_compare[1] | timer_a_low_compare[1];
   assign evt_tma_cmp2 = timer_a_compare[2] | timer_a_low_compare[2];

   // timer B single source, timer D two
   assign evt_tmb = timer_b_irq;
   assign evt_tmd_ovf = timer_d_overflow;
   assign evt_tmd_trig = timer_d_trigger;

   // analog sources
   assign evt_comparator = comparator_irq;
   assign evt_conv_ready = conversion_result_ready;
   assign evt_conv_window = window_compare_hit;

   // two-wire sides and serial peripheral
   assign evt_tw_target = two_wire_target_irq;
   assign evt_tw_controller = two_wire_controller_irq;
   assign evt_spi = spi_irq;

   // serial port sources
   assign evt_ser_rx = receive_complete;
   assign evt_ser_empty = tx_buffer_empty;
   assign evt_ser_tx = transmit_complete;

   // memory controller source
   assign evt_eeprom = eeprom_ready_irq;

   assign nmi_mask = vec_onehot(`IVM_VEC_NMI);
   assign reset_mask = vec_onehot(`IVM_VEC_RESET);

   // event to vector map; vector 0 never carries a maskable source
   always @* begin
      set_evt = {N{1'b0}};
      set_evt[`IVM_VEC_NMI] = evt_checksum_nmi;
      set_evt[`IVM_VEC_VLM] = evt_level_monitor;

      set_evt[`IVM_VEC_PORTA] = evt_port_a;
      set_evt[`IVM_VEC_PORTB] = evt_port_b;
      set_evt[`IVM_VEC_PORTC] = evt_port_c;

      set_evt[`IVM_VEC_RTC_COUNT] = evt_rtc_count;
      set_evt[`IVM_VEC_RTC_TICK] = evt_rtc_tick;

      set_evt[`IVM_VEC_TMA_LOW_UNF] = evt_tma_low_unf;
      set_evt[`IVM_VEC_TMA_HIGH_UNF] = evt_tma_high_unf;
      set_evt[`IVM_VEC_TMA_CMP0] = evt_tma_cmp0;
      set_evt[`IVM_VEC_TMA_CMP1] = evt_tma_cmp1;
      set_evt[`IVM_VEC_TMA_CMP2] = evt_tma_cmp2;

      set_evt[`IVM_VEC_TMB] = evt_tmb;
      set_evt[`IVM_VEC_TMD_OVF] = evt_tmd_ovf;
      set_evt[`IVM_VEC_TMD_TRIG] = evt_tmd_trig;

      set_evt[`IVM_VEC_ACMP] = evt_comparator;
      set_evt[`IVM_VEC_ADC_RDY] = evt_conv_ready;
      set_evt[`IVM_VEC_ADC_WIN] = evt_conv_window;

      set_evt[`IVM_VEC_TW_TGT] = evt_tw_target;
      set_evt[`IVM_VEC_TW_CTL] = evt_tw_controller;
      set_evt[`IVM_VEC_SPI] = evt_spi;

      set_evt[`IVM_VEC_SER_RX] = evt_ser_rx;
      set_evt[`IVM_VEC_SER_EMPTY] = evt_ser_empty;
      set_evt[`IVM_VEC_SER_TX] = evt_ser_tx;

      set_evt[`IVM_VEC_EE] = evt_eeprom;
   end

   ivm_source_flags #(.N(N)) u_flags (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .set_evt(set_evt),
      .clr_flag(flag_clear),
      .en_wr(enable_write),
      .en_wdata(enable_wdata),
      .source_flag_bit(flags),
      .source_enable_bit(enables)
   );

   assign raw_req = flags & enables;
   assign nmi_req = raw_req & nmi_mask;
   assign maskable_req = raw_req & ~nmi_mask & ~reset_mask;

   // global enable gates every maskable vector
   always @* begin
      req_nxt = nmi_req;
      if (global_irq_enable) begin
         req_nxt = req_nxt | maskable_req;
      end
   end

   ivm_prio_enc #(.N(N), .W(W)) u_enc (
      .req(req_nxt),
      .any(any),
      .idx(idx)
   );

   // all outputs hold while clock enable is low
   always @* begin
      flag_reg_nxt = peripheral_flag_register;
      ctrl_reg_nxt = peripheral_irq_control_register;
      vec_req_nxt = vector_request;
      irq_valid_nxt = irq_valid;
      irq_nmi_nxt = irq_nmi;
      irq_vector_nxt = irq_vector;
      if (clk_en) begin
         flag_reg_nxt = flags;
         ctrl_reg_nxt = enables;
         vec_req_nxt = req_nxt;
         irq_valid_nxt = any;
         irq_nmi_nxt = any && (idx == `IVM_VEC_NMI);
         irq_vector_nxt = any ? idx : `IVM_VEC_RESET;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         peripheral_flag_register <= `IVM_FLAGS_RESET;
      end else begin
         peripheral_flag_register <= flag_reg_nxt;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         peripheral_irq_control_register <= `IVM_EN_RESET;
      end else begin
         peripheral_irq_control_register <= ctrl_reg_nxt;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vector_request <= 26'h0000000;
      end else begin
         vector_request <= vec_req_nxt;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_valid <= 1'b0;
      end else begin
         irq_valid <= irq_valid_nxt;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_nmi <= 1'b0;
      end else begin
         irq_nmi <= irq_nmi_nxt;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_vector <= `IVM_VEC_RESET;
      end else begin
         irq_vector <= irq_vector_nxt;
      end
   end
endmodule

/* verif/ivm_mapper_sva.sv */
// port assertions for the vector mapper
`timescale 1ns/1ps
module ivm_mapper_chk (
   input wire sys_clk, rst, clk_en, global_irq_enable, rtc_counter_irq, irq_valid, irq_nmi,
   input wire [25:0] flag_clear, enable_write, enable_wdata, vector_request,
   input wire [25:0] peripheral_flag_register, peripheral_irq_control_register,
   input wire [4:0] irq_vector
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_take(e);
      e && clk_en ##1 clk_en;
   endsequence
   property p_set; s_take(rtc_counter_irq) |=> peripheral_flag_register[6]; endproperty
   a_set: assert property (p_set) else $error("flag not set");
   property p_clr;
      s_take(flag_clear[6] && !rtc_counter_irq) |=> !peripheral_flag_register[6];
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_en;
      s_take(enable_write[6]) |=> peripheral_irq_control_register[6] == $past(enable_wdata[6], 2);
   endproperty
   a_en: assert property (p_en) else $error("enable not written");
   property p_sub;
      (vector_request & ~(peripheral_flag_register & peripheral_irq_control_register)) == 26'h0;
   endproperty
   a_sub: assert property (p_sub) else $error("request without flag and enable");
   property p_gie; !global_irq_enable ##1 !global_irq_enable |-> vector_request[25:2] == 24'h0;
   endproperty
   a_gie: assert property (p_gie) else $error("maskable request while disabled");
   property p_v0; vector_request[0] == 1'b0; endproperty
   a_v0: assert property (p_v0) else $error("request on reset vector");
   property p_nmi; irq_nmi == (irq_valid && irq_vector == 5'h01); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi flag wrong");
   property p_low;
      irq_valid |-> vector_request[irq_vector] &&
         (vector_request & ((26'h1 << irq_vector) - 26'h1)) == 26'h0;
   endproperty
   a_low: assert property (p_low) else $error("not the lowest vector");
endmodule
bind ivm_mapper ivm_mapper_chk chk_u(.*);

/* verif/ivm_core_model.sv */
// core-side model that latches the vector it is offered
`timescale 1ns/1ps
module ivm_core_model (
   input wire sys_clk,
   input wire rst,
   input wire irq_valid,
   input wire [4:0] irq_vector,
   output logic [4:0] taken_vec_r
);
   always @(posedge sys_clk or posedge rst) begin
      if (rst) taken_vec_r <= 5'h00;
      else if (irq_valid) taken_vec_r <= irq_vector;
   end
endmodule

/* verif/ivm_mapper_bench.sv */
// self-checking bench for the vector mapper
`timescale 1ns/1ps
module ivm_mapper_bench;
   logic sys_clk = 0, rst = 1, clk_en = 1, global_irq_enable = 0, ov = 0;
   logic [25:0] ev = 0, flag_clear = 0, enable_write = 0, enable_wdata = 0;
   logic [2:0] lc = 0;
   wire [25:0] peripheral_flag_register, peripheral_irq_control_register, vector_request;
   wire irq_valid, irq_nmi;
   wire [4:0] irq_vector, taken_vec_r;
   int miscompares = 0, checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   ivm_mapper dut_u(.*, .checksum_scan_nmi(ev[1]), .voltage_level_monitor_irq(ev[2]),
      .port_pin_change(ev[5:3]), .rtc_counter_irq(ev[6]), .periodic_tick_irq(ev[7]),
      .low_half_underflow(ev[8]), .timer_a_overflow(ov), .high_half_underflow(ev[9]),
      .timer_a_compare(ev[12:10]), .timer_a_low_compare(lc), .timer_b_irq(ev[13]),
      .timer_d_overflow(ev[14]), .timer_d_trigger(ev[15]), .comparator_irq(ev[16]),
      .conversion_result_ready(ev[17]), .window_compare_hit(ev[18]), .spi_irq(ev[21]),
      .two_wire_target_irq(ev[19]), .two_wire_controller_irq(ev[20]),
      .receive_complete(ev[22]), .tx_buffer_empty(ev[23]), .transmit_complete(ev[24]),
      .eeprom_ready_irq(ev[25]));
   ivm_core_model core_u(.sys_clk(sys_clk), .rst(rst), .irq_valid(irq_valid),
      .irq_vector(irq_vector), .taken_vec_r(taken_vec_r));
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task cmp(input logic [25:0] got, input logic [25:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task t_map;
      enable_write = 26'h3fffffe;
      enable_wdata = 26'h3fffffe;
      global_irq_enable = 1;
      cyc(1);
      enable_write = 0;
      for (int i = 1; i < 26; i++) begin
         ev = 26'h1 << i;
         cyc(1);
         ev = 0;
         cyc(1);
         cmp(peripheral_flag_register, 26'h1 << i);
         cmp(vector_request, 26'h1 << i);
         cmp(irq_vector, i);
         cmp(irq_valid, 1);
         flag_clear = 26'h1 << i;
         cyc(1);
         flag_clear = 0;
         cyc(2);
         cmp(irq_valid, 0);
      end
   endtask
   task t_alt;
      ov = 1;
      lc = 3'h7;
      cyc(1);
      ov = 0;
      lc = 0;
      cyc(1);
      cmp(peripheral_flag_register, 26'h1d00);
      flag_clear = 26'h3ffffff;
      cyc(1);
      flag_clear = 0;
      cyc(2);
   endtask
   task t_gie;
      global_irq_enable = 0;
      ev = 26'h22;
      cyc(1);
      ev = 0;
      cyc(2);
      cmp(vector_request, 26'h2);
      cmp(irq_nmi, 1);
      cmp(taken_vec_r, 1);
      global_irq_enable = 1;
      flag_clear = 26'h2;
      cyc(1);
      flag_clear = 0;
      cyc(2);
      cmp(irq_vector, 5);
   endtask
   task t_mask;
      enable_write = 26'h20;
      enable_wdata = 0;
      cyc(1);
      enable_write = 0;
      cyc(2);
      cmp(peripheral_irq_control_register, 26'h3ffffde);
      cmp(vector_request, 0);
      cmp(peripheral_flag_register, 26'h20);
   endtask
   task t_freeze;
      clk_en = 0;
      ev = 26'h40;
      cyc(1);
      ev = 0;
      cyc(2);
      cmp(peripheral_flag_register, 26'h20);
      cmp(vector_request, 0);
      clk_en = 1;
      cyc(2);
      cmp(peripheral_flag_register, 26'h20);
      cmp(irq_valid, 0);
   endtask
   initial begin
      cyc(16);
      rst = 0;
      cmp(vector_request, 0);
      t_map;
      t_alt;
      t_gie;
      t_mask;
      t_freeze;
      wrap_up;
   end
endmodule
